// [drt_consts.vh]
/*
 * constants for the dual reload down counter timer: register offsets, field
 * positions, reset values, divider masks and bus answers.
 * assumes it is included by bare name from each design file that needs it.
 */
`ifndef DRT_CONSTS_VH
`define DRT_CONSTS_VH

// ********************************************************************
// register map, byte addresses on the axi4-lite bus
// ********************************************************************
`define DRT_ADDR_W 8
`define DRT_OFF_CTRL0 8'h00
`define DRT_OFF_CTRL1 8'h04
`define DRT_OFF_MODE 8'h08
`define DRT_OFF_RELOAD 8'h0C
`define DRT_OFF_COUNT 8'h10
`define DRT_OFF_FLAG 8'h14

// ********************************************************************
// field positions
// ********************************************************************
// per timer control word
`define DRT_BIT_RUN 0
`define DRT_BIT_REPEAT 1
`define DRT_BIT_PRESET 2
`define DRT_BIT_DIV_LO 4
`define DRT_BIT_DIV_HI 5
// mode word
`define DRT_BIT_CHAIN 0
`define DRT_BIT_SRC 1
`define DRT_BIT_STATIC 2
// flag word
`define DRT_BIT_FLAG0 0
`define DRT_BIT_FLAG1 1

// ********************************************************************
// reset values
// ********************************************************************
`define DRT_RST_BIT 1'h0
`define DRT_RST_DIV 2'h0
`define DRT_RST_BYTE 8'h00
`define DRT_RST_PHASE 6'h00

// ********************************************************************
// prescaler masks for divide by 1, 4, 16, 64
// ********************************************************************
`define DRT_DIV_CODE_1 2'h0
`define DRT_DIV_CODE_4 2'h1
`define DRT_DIV_CODE_16 2'h2
`define DRT_DIV_CODE_64 2'h3
`define DRT_DIV_MASK_1 6'h00
`define DRT_DIV_MASK_4 6'h03
`define DRT_DIV_MASK_16 6'h0F
`define DRT_DIV_MASK_64 6'h3F

// ********************************************************************
// axi4-lite answers
// ********************************************************************
`define DRT_RESP_OKAY 2'h0
`define DRT_RESP_SLVERR 2'h2

`endif

// [drt_prescaler.v]
/*
 * prescaler for one timer channel: divides the system clock by 1, 4, 16
 * or 64 and gives a one-cycle tick enable.
 * assumes run and ratio come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "drt_consts.vh"

module drt_prescaler (
	input wire clk,
	input wire sys_rst,
	input wire run,
	input wire [1:0] ratio,
	output wire tick
);

	// ********************************************************************
	// phase counter
	// ********************************************************************
	reg [5:0] phase_reg; // free count while running
	reg [5:0] mask; // low bits that must all be set

	// ratio code to mask
	always @* begin
		case (ratio)
			`DRT_DIV_CODE_1: mask = `DRT_DIV_MASK_1;
			`DRT_DIV_CODE_4: mask = `DRT_DIV_MASK_4;
			`DRT_DIV_CODE_16: mask = `DRT_DIV_MASK_16;
			`DRT_DIV_CODE_64: mask = `DRT_DIV_MASK_64;
			default: mask = `DRT_DIV_MASK_1;
		endcase
	end

	// source clock only reaches the divider while running, so the
	// phase restarts at zero each time the timer is started
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_reg <= `DRT_RST_PHASE;
		end else if (!run) begin
			phase_reg <= `DRT_RST_PHASE;
		end else begin
			phase_reg <= phase_reg + 6'h01;
		end
	end

	// tick when all masked bits are set
	assign tick = run && ((phase_reg & mask) == mask);

endmodule

// [drt_timer.v]
/*
 * dual reload down counter timer with an axi4-lite register slave.
 * assumes one 100 MHz clock for bus and counters, and that the prescaler
 * source clock is the system clock itself.
 */
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "drt_consts.vh"

module drt_timer #(
	parameter INV_PIN_USE = 1 // 1: second pin inverted pulse, 0: static
) (
	input wire clk,
	input wire sys_rst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire underflow_pulse_t0,
	output wire underflow_pulse_t1,
	output wire serial_clk_pulse,
	output wire pulse_out_pin,
	output wire inverted_pulse_out_pin
);

	// ********************************************************************
	// bus slave state
	// ********************************************************************
	reg aw_held_reg; // write address taken, not yet used
	reg [7:0] aw_addr_reg; // held write address
	reg w_held_reg; // write data taken, not yet used
	reg [31:0] w_data_reg; // held write data
	reg [3:0] w_strb_reg; // held byte enables
	reg bvalid_reg; // write answer pending
	reg [1:0] bresp_reg; // write answer code
	reg rvalid_reg; // read answer pending
	reg [31:0] rdata_reg; // read answer data
	reg [1:0] rresp_reg; // read answer code
	// timer state
	reg [7:0] count_t0_reg; // low or lone counter
	reg [7:0] count_t1_reg; // high or lone counter
	reg [7:0] reload_value_t0; // reload for t0
	reg [7:0] reload_value_t1; // reload for t1
	reg run_ctrl_t0; // t0 running
	reg run_ctrl_t1; // t1 running
	reg repeat_select_t0; // t0 continuous
	reg repeat_select_t1; // t1 continuous
	reg [1:0] divide_ratio_t0; // t0 prescaler code
	reg [1:0] divide_ratio_t1; // t1 prescaler code
	reg chain_wide_select; // one 16-bit counter
	reg pulse_source_select; // 0: t0, 1: t1
	reg static_level_reg; // second pin level when static
	reg underflow_flag_t0; // sticky t0 underflow
	reg underflow_flag_t1; // sticky t1 or wide underflow
	reg halved_underflow_out; // toggles per selected underflow
	reg uf_t0_out_reg; // registered t0 underflow pulse
	reg uf_t1_out_reg; // registered t1 underflow pulse
	reg serial_clk_reg; // registered selected underflow pulse

	// write decode: a write fires once both halves are held and no answer is pending
	wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	wire lane0 = do_write && w_strb_reg[0];
	wire lane1 = do_write && w_strb_reg[1];
	wire wr_ctrl0 = lane0 && (aw_addr_reg == `DRT_OFF_CTRL0);
	wire wr_ctrl1 = lane0 && (aw_addr_reg == `DRT_OFF_CTRL1);
	wire wr_mode = lane0 && (aw_addr_reg == `DRT_OFF_MODE);
	wire wr_reload_lo = lane0 && (aw_addr_reg == `DRT_OFF_RELOAD);
	wire wr_reload_hi = lane1 && (aw_addr_reg == `DRT_OFF_RELOAD);
	wire wr_flag = lane0 && (aw_addr_reg == `DRT_OFF_FLAG);
	wire write_mapped = (aw_addr_reg <= `DRT_OFF_FLAG); // dense map from zero, aligned

	// ********************************************************************
	// prescalers and count events
	// ********************************************************************
	wire [1:0] tick_bus; // per timer input clock enable
	// in wide mode t1's ratio is ignored, its run is held low
	wire [1:0] presc_run = {run_ctrl_t1 && !chain_wide_select, run_ctrl_t0};
	wire [3:0] presc_ratio = {divide_ratio_t1, divide_ratio_t0}; // two bits per timer
	wire tick_t0 = tick_bus[0]; // t0 input clock enable
	wire tick_t1 = tick_bus[1]; // t1 input clock enable
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : presc
			drt_prescaler drt_prescaler_i (
				.clk(clk), .sys_rst(sys_rst), .run(presc_run[g]),
				.ratio(presc_ratio[2 * g + 1:2 * g]), .tick(tick_bus[g])
			);
		end
	endgenerate

	wire lo_zero = (count_t0_reg == 8'h00);
	wire hi_zero = (count_t1_reg == 8'h00);
	wire lo_wrap = tick_t0 && lo_zero;
	// wide underflow when both halves wrap
	wire uf_wide = chain_wide_select && lo_wrap && hi_zero;
	wire uf_t0_evt = !chain_wide_select && lo_wrap;
	wire uf_t1_evt = chain_wide_select ? uf_wide : (tick_t1 && hi_zero);
	wire uf_pulse_src = chain_wide_select ? uf_wide :
		(pulse_source_select ? uf_t1_evt : uf_t0_evt);

	// t1 preset ignored in wide mode
	wire preset_strobe_t0 = wr_ctrl0 && w_data_reg[`DRT_BIT_PRESET];
	wire preset_strobe_t1 = wr_ctrl1 && w_data_reg[`DRT_BIT_PRESET] && !chain_wide_select;

	// ********************************************************************
	// counters
	// ********************************************************************
	// two 8-bit counters
	// preset wins over a tick in the same cycle; it is the newer intent
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_t0_reg <= `DRT_RST_BYTE;
			count_t1_reg <= `DRT_RST_BYTE;
		end else begin
			if (preset_strobe_t0) begin
				count_t0_reg <= reload_value_t0;
			end else if (tick_t0) begin
				// lower half wraps to ff while upper still counts
				count_t0_reg <= !lo_zero ? count_t0_reg - 8'h01 :
					((chain_wide_select && !hi_zero) ? 8'hFF : reload_value_t0);
			end
			// high or lone counter
			if (preset_strobe_t1 || (chain_wide_select && preset_strobe_t0)) begin
				count_t1_reg <= reload_value_t1;
			end else if (chain_wide_select ? lo_wrap : tick_t1) begin
				// upper steps only on lower wrap
				// lone t1 on its own tick
				count_t1_reg <= hi_zero ? reload_value_t1 : count_t1_reg - 8'h01;
			end
		end
	end

	// control bits
	// everything cleared: stopped, one-shot, 8-bit
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_ctrl_t0 <= `DRT_RST_BIT;
			run_ctrl_t1 <= `DRT_RST_BIT;
			repeat_select_t0 <= `DRT_RST_BIT;
			repeat_select_t1 <= `DRT_RST_BIT;
			divide_ratio_t0 <= `DRT_RST_DIV;
			divide_ratio_t1 <= `DRT_RST_DIV;
			chain_wide_select <= `DRT_RST_BIT;
			pulse_source_select <= `DRT_RST_BIT;
			static_level_reg <= `DRT_RST_BIT;
			reload_value_t0 <= `DRT_RST_BYTE;
			reload_value_t1 <= `DRT_RST_BYTE;
		end else begin
			// t0 control; a software run write beats the one-shot clear
			if (wr_ctrl0) begin
				run_ctrl_t0 <= w_data_reg[`DRT_BIT_RUN];
				repeat_select_t0 <= w_data_reg[`DRT_BIT_REPEAT];
				divide_ratio_t0 <= w_data_reg[`DRT_BIT_DIV_HI:`DRT_BIT_DIV_LO];
			end else if ((chain_wide_select ? uf_wide : uf_t0_evt) && !repeat_select_t0) begin
				run_ctrl_t0 <= 1'h0;
			end
			// t1 control
			if (wr_ctrl1) begin
				repeat_select_t1 <= w_data_reg[`DRT_BIT_REPEAT];
				divide_ratio_t1 <= w_data_reg[`DRT_BIT_DIV_HI:`DRT_BIT_DIV_LO];
			end
			if (chain_wide_select || (wr_mode && w_data_reg[`DRT_BIT_CHAIN])) begin
				run_ctrl_t1 <= 1'h0;
			end else if (wr_ctrl1) begin
				run_ctrl_t1 <= w_data_reg[`DRT_BIT_RUN];
			end else if (uf_t1_evt && !repeat_select_t1) begin
				run_ctrl_t1 <= 1'h0;
			end
			// repeat set keeps run untouched above
			// mode word
			if (wr_mode) begin
				chain_wide_select <= w_data_reg[`DRT_BIT_CHAIN];
				pulse_source_select <= w_data_reg[`DRT_BIT_SRC];
				static_level_reg <= w_data_reg[`DRT_BIT_STATIC];
			end
			// reload values, one byte lane each
			if (wr_reload_lo) begin
				reload_value_t0 <= w_data_reg[7:0];
			end
			if (wr_reload_hi) begin
				reload_value_t1 <= w_data_reg[15:8];
			end
		end
	end

	// flags, pulses and pins; write one clears, a same-cycle underflow wins
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			underflow_flag_t0 <= `DRT_RST_BIT;
			underflow_flag_t1 <= `DRT_RST_BIT;
			halved_underflow_out <= `DRT_RST_BIT;
			uf_t0_out_reg <= `DRT_RST_BIT;
			uf_t1_out_reg <= `DRT_RST_BIT;
			serial_clk_reg <= `DRT_RST_BIT;
		end else begin
			// t0 flag only outside wide mode
			underflow_flag_t0 <= uf_t0_evt ||
				(underflow_flag_t0 && !(wr_flag && w_data_reg[`DRT_BIT_FLAG0]));
			underflow_flag_t1 <= uf_t1_evt ||
				(underflow_flag_t1 && !(wr_flag && w_data_reg[`DRT_BIT_FLAG1]));
			halved_underflow_out <= halved_underflow_out ^ uf_pulse_src;
			// underflow pulses to interrupt and serial logic
			uf_t0_out_reg <= uf_t0_evt;
			uf_t1_out_reg <= uf_t1_evt;
			serial_clk_reg <= uf_pulse_src;
		end
	end

	assign underflow_pulse_t0 = uf_t0_out_reg;
	assign underflow_pulse_t1 = uf_t1_out_reg;
	assign serial_clk_pulse = serial_clk_reg;
	assign pulse_out_pin = halved_underflow_out;
	// build option for the second pin
	assign inverted_pulse_out_pin = (INV_PIN_USE != 0) ? !halved_underflow_out : static_level_reg;

	// ********************************************************************
	// axi4-lite slave channels
	// ********************************************************************
	// address and data taken in either order; held until both are here
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held_reg <= 1'h0;
			aw_addr_reg <= 8'h00;
			w_held_reg <= 1'h0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'h0;
			bresp_reg <= `DRT_RESP_OKAY;
		end else begin
			// address phase
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'h1;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
			end else if (do_write) begin
				aw_held_reg <= 1'h0;
			end
			// data phase
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'h1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_reg <= 1'h0;
			end
			// answer; unmapped addresses get slverr and change nothing
			if (do_write) begin
				bvalid_reg <= 1'h1;
				bresp_reg <= write_mapped ? `DRT_RESP_OKAY : `DRT_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'h0;
			end
		end
	end

	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// read channel
	// counters read live, no latch needed
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rvalid_reg <= 1'h0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `DRT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'h1;
			rresp_reg <= `DRT_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'h0})
				`DRT_OFF_CTRL0: rdata_reg <= {26'h0, divide_ratio_t0, 2'h0,
					repeat_select_t0, run_ctrl_t0};
				`DRT_OFF_CTRL1: rdata_reg <= {26'h0, divide_ratio_t1, 2'h0,
					repeat_select_t1, run_ctrl_t1};
				`DRT_OFF_MODE: rdata_reg <= {29'h0, static_level_reg,
					pulse_source_select, chain_wide_select};
				`DRT_OFF_RELOAD: rdata_reg <= {16'h0000, reload_value_t1, reload_value_t0};
				`DRT_OFF_COUNT: rdata_reg <= {16'h0000, count_t1_reg, count_t0_reg};
				`DRT_OFF_FLAG: rdata_reg <= {30'h0, underflow_flag_t1, underflow_flag_t0};
				default: begin
					// unmapped: zero data with slverr
					rdata_reg <= 32'h00000000;
					rresp_reg <= `DRT_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'h0;
		end
	end

	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

endmodule

// [drt_timer_asserts.sv]
/*
 * checker for the dual reload down counter timer: bus answers and pulse pins.
 * assumes one clock, reset active high, and sight of the top ports only.
 */
`timescale 1ns/1ps
`include "drt_consts.vh"

module drt_timer_asserts #(
	parameter INV_PIN_USE = 1
) (
	input wire clk,
	input wire sys_rst,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire underflow_pulse_t0,
	input wire underflow_pulse_t1,
	input wire serial_clk_pulse,
	input wire pulse_out_pin,
	input wire inverted_pulse_out_pin
);
	// ********************************************************************
	// one domain, so one clock and one reset for all
	// ********************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	inv_pin_a: assert property (INV_PIN_USE != 1 || inverted_pulse_out_pin == !pulse_out_pin)
		else $error("second pin is not the inverse");
	pin_toggle_a: assert property ($changed(pulse_out_pin) == serial_clk_pulse)
		else $error("pulse pin toggle not tied to selected underflow");
	serial_src_a: assert property (serial_clk_pulse |-> underflow_pulse_t0 || underflow_pulse_t1)
		else $error("serial clock without an underflow");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer not two edges after taking");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not one edge after taking");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not released");

	// main scenarios seen at the pins
	cover property (serial_clk_pulse);
	cover property (underflow_pulse_t1 && !underflow_pulse_t0);
	cover property (s_axi_bvalid && s_axi_bresp == `DRT_RESP_SLVERR);
endmodule

bind drt_timer drt_timer_asserts #(.INV_PIN_USE(INV_PIN_USE)) drt_timer_asserts_i (
	.clk(clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.underflow_pulse_t0(underflow_pulse_t0), .underflow_pulse_t1(underflow_pulse_t1),
	.serial_clk_pulse(serial_clk_pulse), .pulse_out_pin(pulse_out_pin),
	.inverted_pulse_out_pin(inverted_pulse_out_pin)
);

// [drt_timer_tb.sv]
/*
 * self-checking bench for the dual reload down counter timer.
 * assumes the hand-over register map and answer timing of the axi4-lite slave.
 */
`timescale 1ns/1ps
`include "drt_consts.vh"

module drt_timer_tb;
	// ********************************************************************
	// stimulus and observed signals
	// ********************************************************************
	localparam [7:0] OFF_HOLE = 8'h18; // unmapped word
	reg clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [7:0] awaddr = 8'h00;
	reg [7:0] araddr = 8'h00;
	reg [31:0] wdata = 32'h0;
	reg awvalid = 1'b0;
	reg wvalid = 1'b0;
	reg bready = 1'b0;
	reg arvalid = 1'b0;
	reg rready = 1'b0;
	wire awready, wready, bvalid, arready, rvalid, uf0, uf1, sclk, pout, pinv;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	reg [31:0] rdv; // last read data
	reg [1:0] resp; // last bus answer
	integer n_errors, checks_done, i;

	always #5 clk = ~clk;

	drt_timer drt_timer_i (
		.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.underflow_pulse_t0(uf0), .underflow_pulse_t1(uf1), .serial_clk_pulse(sclk),
		.pulse_out_pin(pout), .inverted_pulse_out_pin(pinv)
	);

	// ********************************************************************
	// tasks
	// ********************************************************************
	task close_out;
		begin
			$display("comparisons %0d, mismatches %0d", checks_done, n_errors);
			if (n_errors == 0 && checks_done > 0) begin
				$display("NO MISMATCHES");
			end else begin
				$display("MISMATCHES SEEN");
			end
			$finish;
		end
	endtask

	// a wait that ran out ends the run at once
	task tmo;
		begin
			n_errors = n_errors + 1;
			$display("[FAIL] %0t wait ran out", $time);
			close_out;
		end
	endtask

	task chk(input [31:0] got, input [31:0] exp, input string what);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("[FAIL] %0t %0s got %h expected %h", $time, what, got, exp);
			end
		end
	endtask

	// address and data offered together, each dropped when taken
	task wr(input [7:0] a, input [31:0] d);
		integer k;
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			k = 0;
			do begin
				@(posedge clk);
				k = k + 1;
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
			end while (!bvalid && k < 200);
			resp = bresp;
			bready <= 1'b0;
			if (k >= 200) tmo;
			// one idle edge so the next call never drives in this time step
			@(posedge clk);
		end
	endtask

	task rd(input [7:0] a);
		integer k;
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			k = 0;
			do begin
				@(posedge clk);
				k = k + 1;
				if (arready) arvalid <= 1'b0;
			end while (!rvalid && k < 200);
			rdv = rdata;
			resp = rresp;
			rready <= 1'b0;
			if (k >= 200) tmo;
			@(posedge clk);
		end
	endtask

	// pulse 0: t0, 1: t1, 2: serial clock
	function pl(input integer w);
		pl = (w == 0) ? uf0 : (w == 1) ? uf1 : sclk;
	endfunction

	// cycles between two pulses; the first after a write may be irregular
	task per(input integer w, input integer exp);
		integer k, t;
		begin
			k = 0;
			t = 0;
			while (!pl(w) && k < 1000) begin
				@(posedge clk);
				k = k + 1;
			end
			do begin
				@(posedge clk);
				t = t + 1;
			end while (!pl(w) && t < 1000);
			if (k >= 1000 || t >= 1000) tmo;
			chk(t, exp, "pulse period");
		end
	endtask

	// ********************************************************************
	// main sequence
	// ********************************************************************
	initial begin
		n_errors = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 6; i = i + 1) begin
			rd(i * 4);
			chk(rdv, 32'h0, "reset register");
		end
		chk({pout, pinv}, 32'h1, "reset pins");
		$display("test reset done");
		wr(`DRT_OFF_RELOAD, 32'h0305);
		wr(`DRT_OFF_CTRL0, 32'h04);
		rd(`DRT_OFF_COUNT);
		chk(rdv, 32'h0005, "preset t0");
		wr(`DRT_OFF_CTRL1, 32'h04);
		rd(`DRT_OFF_COUNT);
		chk(rdv, 32'h0305, "preset t1");
		// one-shot from 5 at divide by one
		wr(`DRT_OFF_CTRL0, 32'h01);
		repeat (30) @(posedge clk);
		rd(`DRT_OFF_CTRL0);
		chk(rdv, 32'h0, "run cleared");
		rd(`DRT_OFF_COUNT);
		chk(rdv, 32'h0305, "one-shot reload");
		rd(`DRT_OFF_FLAG);
		chk(rdv, 32'h1, "flag t0");
		$display("test one-shot done");
		// about 94 cycles at divide by 64 gives exactly one tick per run
		for (i = 4; i > 2; i = i - 1) begin
			wr(`DRT_OFF_CTRL0, 32'h31);
			repeat (90) @(posedge clk);
			wr(`DRT_OFF_CTRL0, 32'h30);
			repeat (40) @(posedge clk);
			rd(`DRT_OFF_COUNT);
			chk(rdv, 32'h0300 | i, "stop and resume");
		end
		wr(`DRT_OFF_FLAG, 32'h3);
		rd(`DRT_OFF_FLAG);
		chk(rdv, 32'h0, "flag clear");
		$display("test stop done");
		wr(`DRT_OFF_RELOAD, 32'h0302);
		wr(`DRT_OFF_CTRL0, 32'h07);
		wr(`DRT_OFF_CTRL1, 32'h07);
		wr(`DRT_OFF_MODE, 32'h02);
		per(0, 3);
		per(1, 4);
		per(2, 4);
		wr(`DRT_OFF_MODE, 32'h00);
		per(2, 3);
		for (i = 1; i < 4; i = i + 1) begin
			wr(`DRT_OFF_CTRL0, 32'h07 | (i << 4));
			per(0, 3 << (2 * i));
		end
		$display("test channels done");
		wr(`DRT_OFF_CTRL0, 32'h00);
		wr(`DRT_OFF_CTRL1, 32'h00);
		wr(`DRT_OFF_MODE, 32'h01);
		wr(`DRT_OFF_RELOAD, 32'h0102);
		wr(`DRT_OFF_CTRL0, 32'h07);
		per(1, 259);
		rdv = pout;
		per(2, 259);
		chk(pout ^ rdv[0], 32'h1, "pin toggle");
		chk(pinv ^ pout, 32'h1, "pin inverse");
		wr(`DRT_OFF_CTRL1, 32'h01);
		rd(`DRT_OFF_CTRL1);
		chk(rdv & 32'h1, 32'h0, "t1 run held");
		wr(`DRT_OFF_FLAG, 32'h3);
		repeat (300) @(posedge clk);
		rd(`DRT_OFF_FLAG);
		chk(rdv, 32'h2, "wide flags");
		$display("test wide done");
		wr(OFF_HOLE, 32'hFF);
		chk(resp, `DRT_RESP_SLVERR, "hole write");
		rd(OFF_HOLE);
		chk(resp, `DRT_RESP_SLVERR, "hole read");
		chk(rdv, 32'h0, "hole data");
		$display("test unmapped done");
		close_out;
	end
endmodule
